// [hw/uphy_pkg.sv]
// Operation
// - bit 18 set disables both pull-down groups
// - se0 auto-resume sets bit 13 until cleared
// - k auto-resume sets bit 12 until cleared
// - line-state change delayed two-power bits 11:8
// - bit 7 selects hardware or polled resume
// - bits 6:4 drive transceiver config inputs
package uphy_pkg;
  // register byte addresses
  localparam logic [7:0]  ADDR_CTRL     = 8'h40;
  localparam logic [7:0]  ADDR_STATUS   = 8'h44;
  localparam logic [7:0]  ADDR_MASK     = 8'h48;
  localparam logic [7:0]  ADDR_LINE     = 8'h4c;
  // control field positions
  localparam int          PD_DIS_BIT    = 18;
  localparam int          RES_SE0_BIT   = 13;
  localparam int          RES_K_BIT     = 12;
  localparam int          FILT_LSB      = 8;
  localparam int          FILT_MSB      = 11;
  localparam int          AUTO_RES_BIT  = 7;
  localparam int          CFG_LSB       = 4;
  localparam int          CFG_MSB       = 6;
  localparam logic [31:0] CTRL_RW_MASK  = 32'h0004_3ff0;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  // interrupt status bits
  localparam int          IRQ_SE0_BIT   = 0;
  localparam int          IRQ_K_BIT     = 1;
  localparam int          IRQ_LINE_BIT  = 2;
  localparam int          IRQ_W         = 3;
  localparam logic [2:0]  IRQ_RESET     = 3'h0;
  // line states
  localparam logic [1:0]  LS_SE0        = 2'h0;
  localparam logic [1:0]  LS_J          = 2'h1;
  localparam logic [1:0]  LS_K          = 2'h2;
  localparam int          FILT_CNT_W    = 16;
  // suspend controller
  typedef enum logic [1:0] {
    ST_RUN    = 2'h0,
    ST_SUSP   = 2'h1,
    ST_RESUME = 2'h3
  } uphy_state_t;
endpackage : uphy_pkg

// [hw/uphy_linefilt.sv]
`timescale 1ns/1ps
module uphy_linefilt
  import uphy_pkg::*;
(
  input  wire logic       pclk,     // interface clock
  input  wire logic       presetn,  // async reset, active low
  input  wire logic [3:0] lim_log,  // log2 of hold cycles
  input  wire logic [1:0] din,      // synchronised line state
  output logic      [1:0] dout      // filtered line state
);
  logic [1:0]            cand;
  logic [FILT_CNT_W-1:0] cnt;
  wire  [FILT_CNT_W-1:0] lim = (FILT_CNT_W'(1) << lim_log) - FILT_CNT_W'(1);

  // a new value must hold steady 2^n cycles; a bounce restarts the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cand <= LS_SE0;
      cnt  <= '0;
      dout <= LS_SE0;
    end else if (din == dout) begin
      cand <= din;
      cnt  <= '0;
    end else if (din != cand) begin
      cand <= din;
      cnt  <= '0;
    // compare with >= so that a limit lowered mid-count cannot strand cnt above it
    end else if (cnt >= lim) begin
      dout <= din;
      cnt  <= '0;
    end else begin
      cnt <= cnt + FILT_CNT_W'(1);
    end
  end

  filt_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (dout != $past(dout)) |-> ($past(cnt) >= $past(lim) && $past(din) == dout))
    else $error("filtered line state changed before hold time");
endmodule : uphy_linefilt

// [hw/uphy_ctrl.sv]
`timescale 1ns/1ps
module uphy_ctrl
  import uphy_pkg::*;
(
  input  wire logic        pclk,          // interface clock, 40 MHz
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb enable
  input  wire logic        pwrite,        // apb direction
  input  wire logic [7:0]  paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error, unmapped address
  input  wire logic [1:0]  line_state,    // raw transceiver line state pins
  input  wire logic        suspend_req,   // suspend request from usb_interface_unit
  output logic [1:0]       pulldown_disable,          // one per port group
  output logic [2:0]       transceiver_config_inputs, // to transceiver pins
  output logic             resume_pulse,  // hardware resume done
  output logic             irq            // level interrupt
);
  ////////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic [31:0]    ctrl;
  logic [IRQ_W-1:0] status;
  logic [IRQ_W-1:0] mask;
  logic [1:0]     ls_s1, ls_s2, ls_s3, ls_stable, ls_filt, ls_filt_q;
  uphy_state_t    state;
  uphy_state_t    next_state;

  wire access   = psel & penable & pready;
  wire hit_ctrl = paddr == ADDR_CTRL;
  wire hit_stat = paddr == ADDR_STATUS;
  wire hit_mask = paddr == ADDR_MASK;
  wire hit_line = paddr == ADDR_LINE;
  wire mapped   = hit_ctrl | hit_stat | hit_mask | hit_line;
  wire wr_ctrl  = access & pwrite & hit_ctrl;
  wire wr_mask  = access & pwrite & hit_mask;
  wire rd_stat  = access & !pwrite & hit_stat;

  // reserved bits come back as zero because ctrl never stores them
  wire [31:0] rd_val = hit_ctrl ? ctrl :
                       hit_stat ? {29'h0, status} :
                       hit_mask ? {29'h0, mask} :
                       hit_line ? {28'h0, state, ls_filt} : 32'h0;

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & !pready;
      prdata  <= (psel & penable & !pready & !pwrite) ? rd_val : 32'h0;
      pslverr <= psel & penable & !pready & !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // line state: three stages, a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_s1     <= LS_SE0;
      ls_s2     <= LS_SE0;
      ls_s3     <= LS_SE0;
      ls_stable <= LS_SE0;
      ls_filt_q <= LS_SE0;
    end else begin
      ls_s1     <= line_state;
      ls_s2     <= ls_s1;
      ls_s3     <= ls_s2;
      ls_stable <= (ls_s2 == ls_s3) ? ls_s3 : ls_stable;
      ls_filt_q <= ls_filt;
    end
  end

  uphy_linefilt u_filt (
    .pclk    (pclk),
    .presetn (presetn),
    .lim_log (ctrl[FILT_MSB:FILT_LSB]),
    .din     (ls_stable),
    .dout    (ls_filt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // suspend controller
  wire auto_res  = ctrl[AUTO_RES_BIT];
  wire wake_line = (ls_filt == LS_K) | (ls_filt == LS_SE0);
  wire ev_se0    = (state == ST_RESUME) & (ls_filt == LS_SE0);
  wire ev_k      = (state == ST_RESUME) & (ls_filt == LS_K);
  wire ev_line   = ls_filt != ls_filt_q;

  // without auto resume software polls the line register and drops suspend_req
  always_comb begin
    case (state)
      // the unit needs the pulse cycle to drop its request, else suspend is re-entered
      ST_RUN:    next_state = (suspend_req & !resume_pulse) ? ST_SUSP : ST_RUN;
      ST_SUSP:   next_state = (auto_res & wake_line) ? ST_RESUME :
                              (suspend_req ? ST_SUSP : ST_RUN);
      ST_RESUME: next_state = ST_RUN;
      default:   next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= ST_RUN;
      resume_pulse <= 1'b0;
    end else begin
      state        <= next_state;
      resume_pulse <= state == ST_RESUME;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control register: hardware set of a resume flag wins over a clearing write
  wire [31:0] ctrl_wr = (pwdata & CTRL_RW_MASK) | (ctrl & ~CTRL_RW_MASK);
  wire        se0_w0  = wr_ctrl & !pwdata[RES_SE0_BIT];
  wire        k_w0    = wr_ctrl & !pwdata[RES_K_BIT];
  wire        next_se0 = ev_se0 | (ctrl[RES_SE0_BIT] & !se0_w0);
  wire        next_k   = ev_k | (ctrl[RES_K_BIT] & !k_w0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else begin
      ctrl <= wr_ctrl ? ctrl_wr : ctrl;
      ctrl[RES_SE0_BIT] <= next_se0;
      ctrl[RES_K_BIT]   <= next_k;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky events, cleared by reading status, set wins over the read
  wire [IRQ_W-1:0] events = {ev_line, ev_k, ev_se0};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= IRQ_RESET;
      mask   <= IRQ_RESET;
      irq    <= 1'b0;
    end else begin
      status <= events | (rd_stat ? IRQ_RESET : status);
      mask   <= wr_mask ? pwdata[IRQ_W-1:0] : mask;
      irq    <= |(status & mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin outputs straight from the control flops
  assign pulldown_disable          = {2{ctrl[PD_DIS_BIT]}};
  assign transceiver_config_inputs = ctrl[CFG_MSB:CFG_LSB];

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  pd_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> pulldown_disable == {2{$past(pwdata[PD_DIS_BIT])}})
    else $error("pull-down disable does not follow write");

  se0_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev_se0 |=> ctrl[RES_SE0_BIT] ##1 ctrl[RES_SE0_BIT] || $past(se0_w0))
    else $error("se0 resume flag not set");

  se0_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl[RES_SE0_BIT] && !se0_w0) |=> ctrl[RES_SE0_BIT])
    else $error("se0 resume flag dropped without clearing write");

  k_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_k || (ctrl[RES_K_BIT] && !k_w0)) |=> ctrl[RES_K_BIT])
    else $error("k resume flag not set or not held");

  poll_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_SUSP && !auto_res) |=> state != ST_RESUME)
    else $error("hardware resume while auto resume is off");

  cfg_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> transceiver_config_inputs == $past(pwdata[CFG_MSB:CFG_LSB]))
    else $error("transceiver config pins do not follow write");

  rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready && !pwrite && hit_ctrl) |=> (prdata & ~CTRL_RW_MASK) == 32'h0)
    else $error("reserved control bits read non-zero");

  pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready stood longer than one cycle");

  err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("slave error without ready");

  rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && penable && !pready && !pwrite) |=> prdata == 32'h0)
    else $error("read data not zero outside a read");

  stat_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_stat |=> status == $past(events))
    else $error("status not cleared by read, or event lost");

  stat_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rd_stat |=> (status & $past(status)) == $past(status))
    else $error("status bit dropped without a read");

  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |$past(status & mask))
    else $error("interrupt does not follow masked status");

  line_evt_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ls_filt != ls_filt_q) |=> status[IRQ_LINE_BIT])
    else $error("filtered line change did not set status");

  wake_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
    resume_pulse |=> state != ST_SUSP)
    else $error("suspend re-entered while resume was reported");

  cfg_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_ctrl |=> $stable(transceiver_config_inputs))
    else $error("transceiver config pins changed without a write");

  auto_wake_c: cover property (@(posedge pclk) disable iff (!presetn)
    state == ST_SUSP ##1 state == ST_RESUME ##1 resume_pulse);
  irq_c: cover property (@(posedge pclk) disable iff (!presetn) irq ##[1:4] rd_stat);
  line_c: cover property (@(posedge pclk) disable iff (!presetn) ev_line && ctrl[FILT_MSB]);
  poll_c: cover property (@(posedge pclk) disable iff (!presetn)
    state == ST_SUSP && !auto_res && ls_filt == LS_K);
endmodule : uphy_ctrl

// [tb/uphy_xcvr_model.sv]
`timescale 1ns/1ps
module uphy_xcvr_model
  import uphy_pkg::*;
(
  input  wire logic       pclk,       // interface clock
  input  wire logic [1:0] want,       // steady symbol on the line
  input  wire logic       bounce,     // show a short glitch
  output logic      [1:0] line_state  // line as the block sees it
);
  import uphy_pkg::*;
  // the line is always driven; a bounce flips both wires so it never rests
  always_ff @(posedge pclk) begin
    line_state <= bounce ? ~want : want;
  end
endmodule : uphy_xcvr_model

// [tb/usb_phy_control_reg_test.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module usb_phy_control_reg_test;
  import uphy_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, bounce, susp;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, er, resume_pulse, irq;
  logic [1:0]  line_state, want, pulldown_disable;
  logic [2:0]  transceiver_config_inputs;
  int          errors = 0;
  int          comparisons = 0;
  int          pulses = 0;
  // plain rows: written word, word read back
  logic [31:0] wd [4] = '{32'hffff_ffff, 32'h0000_0050, 32'h0004_0000, 32'h0000_f00f};
  logic [31:0] ex [4] = '{32'h0004_0ff0, 32'h0000_0050, 32'h0004_0000, 32'h0000_0000};
  always #12.5 pclk = ~pclk;
  uphy_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_state(line_state), .suspend_req(susp),
    .pulldown_disable(pulldown_disable),
    .transceiver_config_inputs(transceiver_config_inputs),
    .resume_pulse(resume_pulse), .irq(irq));
  uphy_xcvr_model far (.pclk(pclk), .want(want), .bounce(bounce), .line_state(line_state));
  // the pulse stands one cycle, so count it on every edge
  always @(posedge pclk) if (resume_pulse === 1'b1) pulses++;
  //////////////////////////////////////////////////////////////////////////
  // one idle cycle before each setup keeps psel from being driven twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // the line settles to J before suspend, since a filtered K or SE0 wakes at once;
  // the unit model drops its request on the edge that shows the resume pulse
  task automatic wake(input logic [1:0] ls, input int b, input int s);
    int n;
    want <= LS_J;
    apb(1'b1, ADDR_CTRL, 32'h80);
    repeat (20) @(posedge pclk);
    susp <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b0, ADDR_LINE, 32'h0); `CHK("suspended", 2'h1, rd[3:2])
    n = pulses;
    want <= ls;
    for (int k = 0; k < 100 && resume_pulse !== 1'b1; k++) @(posedge pclk);
    susp <= 1'b0;
    want <= LS_J;
    apb(1'b0, ADDR_CTRL, 32'h0); `CHK("flag", 32'h80 | (32'h1 << b), rd)
    `CHK("pulse", n + 1, pulses)
    apb(1'b0, ADDR_STATUS, 32'h0); `CHK("wake evt", 2'(1 << s), rd[1:0])
    apb(1'b1, ADDR_CTRL, 32'h80);
    apb(1'b0, ADDR_CTRL, 32'h0); `CHK("flag clr", 32'h80, rd)
  endtask : wake
  task automatic close_out;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  //////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
    pwdata = 32'h0; want = LS_J; bounce = 1'b0; susp = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0); `CHK("ctrl reset", 32'h0, rd)
    foreach (wd[i]) begin
      apb(1'b1, ADDR_CTRL, wd[i]);
      apb(1'b0, ADDR_CTRL, 32'h0); `CHK("ctrl", ex[i], rd)
      `CHK("pulldown", {2{ex[i][18]}}, pulldown_disable)
      `CHK("config", ex[i][6:4], transceiver_config_inputs)
    end
    // unmapped place: error flagged, nothing stored
    apb(1'b1, 8'h10, 32'hffff_ffff); `CHK("err wr", 1'b1, er)
    apb(1'b0, 8'h10, 32'h0); `CHK("err rd", 32'h0, rd)
    // filter of 2^3 cycles; a change must not pass within one read
    apb(1'b1, ADDR_CTRL, 32'h300);
    apb(1'b1, ADDR_MASK, 32'h4);
    repeat (30) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    want <= LS_K;
    apb(1'b0, ADDR_LINE, 32'h0); `CHK("held", LS_J, rd[1:0])
    repeat (20) @(posedge pclk);
    apb(1'b0, ADDR_LINE, 32'h0); `CHK("passed", LS_K, rd[1:0])
    `CHK("irq on", 1'b1, irq)
    apb(1'b0, ADDR_STATUS, 32'h0); `CHK("line evt", 1'b1, rd[IRQ_LINE_BIT])
    repeat (3) @(posedge pclk);
    `CHK("irq off", 1'b0, irq)
    bounce <= 1'b1;
    repeat (3) @(posedge pclk);
    bounce <= 1'b0;
    repeat (20) @(posedge pclk);
    apb(1'b0, ADDR_LINE, 32'h0); `CHK("glitch", LS_K, rd[1:0])
    apb(1'b1, ADDR_MASK, 32'h0);
    wake(LS_K, RES_K_BIT, IRQ_K_BIT);
    wake(LS_SE0, RES_SE0_BIT, IRQ_SE0_BIT);
    // polled mode: the controller must not wake by itself
    apb(1'b1, ADDR_CTRL, 32'h0);
    susp <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b0, ADDR_LINE, 32'h0); `CHK("poll susp", 4'h5, rd[3:0])
    want <= LS_K;
    repeat (30) @(posedge pclk);
    apb(1'b0, ADDR_LINE, 32'h0); `CHK("polled", 4'h6, rd[3:0])
    apb(1'b0, ADDR_CTRL, 32'h0); `CHK("no flag", 32'h0, rd)
    susp <= 1'b0;
    // mid-run reset: registers and pin outputs drop to zero at once
    apb(1'b1, ADDR_CTRL, 32'h0004_0070);
    apb(1'b1, ADDR_MASK, 32'h7);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("rst pd", 2'h0, pulldown_disable)
    `CHK("rst cfg", 3'h0, transceiver_config_inputs)
    `CHK("rst irq", 1'b0, irq)
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0); `CHK("ctrl re-reset", 32'h0, rd)
    apb(1'b0, ADDR_MASK, 32'h0); `CHK("mask re-reset", 32'h0, rd)
    close_out();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #500000;
    errors++;
    close_out();
  end
endmodule : usb_phy_control_reg_test
